// file: src/i2cs_pkg.sv
// Purpose: constants and types of the two-wire slave transmit block
// Assumes: one system clock, the bus clock pin clocks the link logic
// Notes: shared by the core and the link logic
//
// Summary of operation
// - a matched address with read direction sets the read/write status bit
// - a matched read address byte is placed in the serial buffer register
// - the device pulls the data line low for the ninth address clock
// - after acknowledging a read address the clock line is held low
// - a software buffer write also loads the transmit shift register
// - the held clock line is released only once software sets the release bit
// - eight data bits change on falling clock edges, stable while clock high
// - the master's acknowledge is taken on the ninth rising clock edge
// - a high acknowledge ends the transfer; slave waits for next start
// - each byte of a frame with a matching address raises the serial port interrupt flag, up to the byte with a high acknowledge
// - the flag is set on the falling edge of the ninth clock
// - with stretch enabled the clock is held after each received data byte, not after a write address byte

package i2cs_pkg;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] BIT_ONE = 4'h1;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [2:0] TX_ZERO = 3'h0;
    localparam logic [2:0] TX_ONE = 3'h1;
    localparam logic [2:0] TX_LAST = 3'h7;
    localparam int TX_MSB = 7;
    localparam int TX_NEXT = 6;
    localparam int ADDR_MSB = 7;
    localparam int ADDR_LSB = 1;
    localparam int RW_POS = 0;
    localparam logic RW_READ = 1'b1;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam int TOG_ACK = 0;
    localparam int TOG_DONE = 1;
    localparam int TOG_BIT = 2;
    localparam logic [2:0] TOG_RESET = 3'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HOLD = 2'b01,
        ST_SEND = 2'b11,
        ST_RECV = 2'b10
    } i2cs_state_e;

    typedef enum logic [1:0] {
        LK_ADDR = 2'b00,
        LK_TX = 2'b01,
        LK_RX = 2'b11,
        LK_DEAD = 2'b10
    } i2cs_phase_e;
endpackage

// file: src/i2cs_link_if.sv
// Purpose: carrier between the core and the bus-clocked link logic
// Assumes: toggles cross to the core through two flip-flops
// Notes: data words are stable whenever their toggle changes
`timescale 1ns/1ps
`default_nettype none

interface i2cs_link_if;
    logic [6:0] ownAddr;
    logic frameRst;
    logic ackTog;
    logic doneTog;
    logic bitTog;
    logic [7:0] rxByte;
    logic ackBit;
    logic addrByte;
    logic readDir;

    modport link (
        input ownAddr, frameRst,
        output ackTog, doneTog, bitTog, rxByte, ackBit, addrByte, readDir
    );
    modport core (
        output ownAddr, frameRst,
        input ackTog, doneTog, bitTog, rxByte, ackBit, addrByte, readDir
    );
endinterface

`default_nettype wire

// file: src/i2cs_link.sv
// Purpose: link logic clocked by the incoming bus clock
// Assumes: frameRst is raised by the core on start and stop
// Notes: bus clock stands still outside frames
`timescale 1ns/1ps
`default_nettype none

module i2cs_link
    import i2cs_pkg::*;
(
    input wire logic arst_n,
    input wire logic serialClockIn,
    input wire logic serialDataIn,
    i2cs_link_if.link lnk
);
    logic frameRstN;
    logic [3:0] bitCnt_q;
    logic [7:0] rxShift_q;
    logic ackBit_q, readDir_q, addrByte_q, seenBit_q;
    logic ackTog_q, doneTog_q, bitTog_q;
    i2cs_phase_e phase_q;
    logic atAck, atDone, match;

    function automatic logic addrMatch(input logic [7:0] b,
                                       input logic [6:0] own);
        addrMatch = (b[ADDR_MSB:ADDR_LSB] == own);
    endfunction

    assign frameRstN = arst_n & ~lnk.frameRst;
    assign atAck = (bitCnt_q == BIT_ACK);
    // the clock fall of a start condition is not a byte end
    assign atDone = seenBit_q && (bitCnt_q == BIT_ZERO) &&
                    (phase_q != LK_DEAD);
    assign match = addrMatch(rxShift_q, lnk.ownAddr);

    // ========================================
    // rising edges: bits in, acknowledge latch
    always_ff @(posedge serialClockIn or negedge frameRstN) begin
        if (!frameRstN) begin
            bitCnt_q <= BIT_ZERO;
            rxShift_q <= BYTE_RESET;
            ackBit_q <= 1'b1;
            seenBit_q <= 1'b0;
        end else if (atAck) begin
            bitCnt_q <= BIT_ZERO;
            ackBit_q <= serialDataIn;
        end else begin
            bitCnt_q <= bitCnt_q + BIT_ONE;
            seenBit_q <= 1'b1;
            rxShift_q <= {rxShift_q[TX_NEXT:0], serialDataIn};
        end
    end

    // ========================================
    // falling edges: phase of the frame
    always_ff @(negedge serialClockIn or negedge frameRstN) begin
        if (!frameRstN) begin
            phase_q <= LK_ADDR;
            readDir_q <= 1'b0;
            addrByte_q <= 1'b1;
        end else if (atAck && phase_q == LK_ADDR) begin
            if (!match) begin
                phase_q <= LK_DEAD;
            end else begin
                readDir_q <= (rxShift_q[RW_POS] == RW_READ);
            end
        end else if (atDone) begin
            addrByte_q <= (phase_q == LK_ADDR);
            if (phase_q == LK_ADDR) begin
                phase_q <= readDir_q ? LK_TX : LK_RX;
            end else if (phase_q == LK_TX && ackBit_q) begin
                phase_q <= LK_DEAD;
            end
        end
    end

    // ========================================
    // event toggles towards the core
    always_ff @(negedge serialClockIn or negedge arst_n) begin
        if (!arst_n) begin
            ackTog_q <= 1'b0;
            doneTog_q <= 1'b0;
            bitTog_q <= 1'b0;
        end else begin
            if (atAck && ((phase_q == LK_ADDR && match) ||
                          phase_q == LK_RX)) begin
                ackTog_q <= ~ackTog_q;
            end
            if (atDone) begin
                doneTog_q <= ~doneTog_q;
            end
            if (phase_q == LK_TX && bitCnt_q != BIT_ZERO) begin
                bitTog_q <= ~bitTog_q;
            end
        end
    end

    assign lnk.ackTog = ackTog_q;
    assign lnk.doneTog = doneTog_q;
    assign lnk.bitTog = bitTog_q;
    assign lnk.rxByte = rxShift_q;
    assign lnk.ackBit = ackBit_q;
    assign lnk.addrByte = addrByte_q;
    assign lnk.readDir = readDir_q;
endmodule

`default_nettype wire

// file: src/i2cs_slave_tx.sv
// Purpose: slave transmit path of a two-wire serial port
// Assumes: ownAddress is stable while the bus is active
// Notes: lines are only pulled low; external pull-ups set the high level
`timescale 1ns/1ps
`default_nettype none

module i2cs_slave_tx
    import i2cs_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic serialClockIn,
    output logic serialClockOut,
    output logic serialClockOe,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOe,
    input wire logic [6:0] ownAddress,
    input wire logic clockStretchEnable,
    input wire logic [7:0] txData,
    input wire logic txWrite,
    input wire logic releaseClock,
    input wire logic intClear,
    output logic [7:0] serialBuffer,
    output logic statusReadWrite,
    output logic statusDataByte,
    output logic statusNack,
    output logic clockReleaseBit,
    output logic serialPortIntFlag
);
    // ========================================
    // declarations
    i2cs_link_if lnk();

    logic clS1_q, clS2_q, clS3_q;
    logic dlS1_q, dlS2_q, dlS3_q;
    logic [2:0] togS1_q, togS2_q, togS3_q;
    logic frameRst_q;
    logic ackEv, doneEv, bitEv;
    logic startEv, stopEv;

    i2cs_state_e state_q;
    logic [2:0] txCnt_q;
    logic [7:0] transmitShift_q;
    logic [7:0] serialBuffer_q;
    logic statusReadWrite_q;
    logic statusDataByte_q;
    logic statusNack_q;
    logic clockReleaseBit_q;
    logic serialPortIntFlag_q;
    logic serialClockOe_q;
    logic serialDataOe_q;
    logic serialClockOut_q;
    logic serialDataOut_q;

    // ========================================
    // link logic on the bus clock
    assign lnk.ownAddr = ownAddress;
    assign lnk.frameRst = frameRst_q;

    i2cs_link uLink (
        .arst_n(arst_n),
        .serialClockIn(serialClockIn),
        .serialDataIn(serialDataIn),
        .lnk(lnk)
    );

    // ========================================
    // synchronisers for pins and toggles
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clS1_q <= 1'b1;
            clS2_q <= 1'b1;
            clS3_q <= 1'b1;
            dlS1_q <= 1'b1;
            dlS2_q <= 1'b1;
            dlS3_q <= 1'b1;
        end else begin
            clS1_q <= serialClockIn;
            clS2_q <= clS1_q;
            clS3_q <= clS2_q;
            dlS1_q <= serialDataIn;
            dlS2_q <= dlS1_q;
            dlS3_q <= dlS2_q;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            togS1_q <= TOG_RESET;
            togS2_q <= TOG_RESET;
            togS3_q <= TOG_RESET;
        end else begin
            togS1_q <= {lnk.bitTog, lnk.doneTog, lnk.ackTog};
            togS2_q <= togS1_q;
            togS3_q <= togS2_q;
        end
    end

    assign ackEv = togS2_q[TOG_ACK] ^ togS3_q[TOG_ACK];
    assign doneEv = togS2_q[TOG_DONE] ^ togS3_q[TOG_DONE];
    assign bitEv = togS2_q[TOG_BIT] ^ togS3_q[TOG_BIT];
    assign startEv = clS2_q && clS3_q && dlS3_q && !dlS2_q;
    assign stopEv = clS2_q && clS3_q && !dlS3_q && dlS2_q;

    // ========================================
    // frame reset of the link logic
    // held from start or stop until the clock line goes low, so the
    // link never sees a clock edge while its reset is released
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            frameRst_q <= 1'b1;
        end else if (startEv || stopEv) begin
            frameRst_q <= 1'b1;
        end else if (!clS2_q) begin
            frameRst_q <= 1'b0;
        end
    end

    // ========================================
    // transfer state, line drivers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
            serialClockOe_q <= 1'b0;
            serialDataOe_q <= 1'b0;
            txCnt_q <= TX_ZERO;
        end else if (startEv || stopEv) begin
            state_q <= ST_IDLE;
            serialClockOe_q <= 1'b0;
            serialDataOe_q <= 1'b0;
        end else if (ackEv) begin
            serialDataOe_q <= 1'b1;
        end else if (doneEv) begin
            serialDataOe_q <= 1'b0;
            if (lnk.addrByte) begin
                if (lnk.readDir) begin
                    state_q <= ST_HOLD;
                    serialClockOe_q <= 1'b1;
                end else begin
                    state_q <= ST_RECV;
                end
            end else begin
                case (state_q)
                    ST_SEND: begin
                        if (lnk.ackBit) begin
                            state_q <= ST_IDLE;
                        end else begin
                            state_q <= ST_HOLD;
                            serialClockOe_q <= 1'b1;
                        end
                    end
                    ST_RECV: begin
                        if (clockStretchEnable) begin
                            state_q <= ST_HOLD;
                            serialClockOe_q <= 1'b1;
                        end
                    end
                    default: begin
                        state_q <= state_q;
                    end
                endcase
            end
        end else begin
            case (state_q)
                ST_HOLD: begin
                    if (clockReleaseBit_q) begin
                        serialClockOe_q <= 1'b0;
                        txCnt_q <= TX_ZERO;
                        state_q <= statusReadWrite_q ? ST_SEND : ST_RECV;
                    end else if (txWrite && statusReadWrite_q) begin
                        // first bit is set up while the clock is held
                        serialDataOe_q <= ~txData[TX_MSB];
                    end
                end
                ST_SEND: begin
                    if (bitEv) begin
                        if (txCnt_q != TX_LAST) begin
                            serialDataOe_q <= ~transmitShift_q[TX_NEXT];
                            txCnt_q <= txCnt_q + TX_ONE;
                        end else begin
                            serialDataOe_q <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_q <= state_q;
                end
            endcase
        end
    end

    // ========================================
    // transmit shift register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            transmitShift_q <= BYTE_RESET;
        end else if (txWrite) begin
            transmitShift_q <= txData;
        end else if (state_q == ST_SEND && bitEv && txCnt_q != TX_LAST) begin
            transmitShift_q <= {transmitShift_q[TX_NEXT:0], 1'b0};
        end
    end

    // ========================================
    // serial buffer register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            serialBuffer_q <= BYTE_RESET;
        end else if (doneEv && (lnk.addrByte || state_q == ST_RECV)) begin
            serialBuffer_q <= lnk.rxByte;
        end else if (txWrite) begin
            serialBuffer_q <= txData;
        end
    end

    // ========================================
    // serial status register bits
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            statusReadWrite_q <= 1'b0;
            statusDataByte_q <= 1'b0;
            statusNack_q <= 1'b0;
        end else if (doneEv) begin
            if (lnk.addrByte) begin
                statusReadWrite_q <= lnk.readDir;
            end
            statusDataByte_q <= !lnk.addrByte;
            if (!lnk.addrByte && state_q == ST_SEND) begin
                statusNack_q <= lnk.ackBit;
            end
        end
    end

    // ========================================
    // clock release control bit
    // software set wins over the hardware clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clockReleaseBit_q <= 1'b0;
        end else if (releaseClock) begin
            clockReleaseBit_q <= 1'b1;
        end else if (doneEv) begin
            clockReleaseBit_q <= 1'b0;
        end
    end

    // ========================================
    // serial port interrupt flag, set wins over clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            serialPortIntFlag_q <= 1'b0;
        end else if (doneEv) begin
            serialPortIntFlag_q <= 1'b1;
        end else if (intClear) begin
            serialPortIntFlag_q <= 1'b0;
        end
    end

    // ========================================
    // pin levels: pulled low only
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            serialClockOut_q <= 1'b0;
            serialDataOut_q <= 1'b0;
        end else begin
            serialClockOut_q <= 1'b0;
            serialDataOut_q <= 1'b0;
        end
    end

    assign serialClockOut = serialClockOut_q;
    assign serialClockOe = serialClockOe_q;
    assign serialDataOut = serialDataOut_q;
    assign serialDataOe = serialDataOe_q;
    assign serialBuffer = serialBuffer_q;
    assign statusReadWrite = statusReadWrite_q;
    assign statusDataByte = statusDataByte_q;
    assign statusNack = statusNack_q;
    assign clockReleaseBit = clockReleaseBit_q;
    assign serialPortIntFlag = serialPortIntFlag_q;

    // ========================================
    // assertions
    default clocking cbSys @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    a_rw_on_read: assert property (
        doneEv && lnk.addrByte && lnk.readDir && !startEv && !stopEv
        |=> statusReadWrite_q)
        else $error("read address did not set read/write status");

    a_buffer_addr: assert property (
        doneEv && lnk.addrByte && lnk.readDir
        |=> serialBuffer_q == $past(lnk.rxByte))
        else $error("address byte not placed in buffer");

    a_ack_drive: assert property (
        ackEv && !startEv && !stopEv |=> serialDataOe_q)
        else $error("acknowledge not driven");

    a_hold_read: assert property (
        doneEv && lnk.addrByte && lnk.readDir && !startEv && !stopEv
        |=> serialClockOe_q && state_q == ST_HOLD)
        else $error("clock not held after read address");

    a_tx_load: assert property (
        txWrite && !doneEv
        |=> transmitShift_q == $past(txData) &&
            serialBuffer_q == $past(txData))
        else $error("buffer write did not load shift register");

    a_release_gate: assert property (
        $fell(serialClockOe_q) && !$past(startEv) && !$past(stopEv)
        |-> $past(clockReleaseBit_q))
        else $error("clock released without release bit");

    a_shift_out: assert property (
        state_q == ST_SEND && bitEv && txCnt_q != TX_LAST && !ackEv &&
        !doneEv && !startEv && !stopEv
        |=> serialDataOe_q == !$past(transmitShift_q[TX_NEXT]))
        else $error("wrong data bit driven");

    a_nack_end: assert property (
        doneEv && !lnk.addrByte && state_q == ST_SEND && lnk.ackBit &&
        !ackEv && !startEv && !stopEv
        |=> state_q == ST_IDLE && !serialClockOe_q [*2])
        else $error("transfer not ended on high acknowledge");

    a_int_set: assert property (
        doneEv |=> serialPortIntFlag_q)
        else $error("interrupt flag not set for byte");

    a_stretch_rx: assert property (
        doneEv && !lnk.addrByte && state_q == ST_RECV &&
        clockStretchEnable && !ackEv && !startEv && !stopEv
        |=> serialClockOe_q)
        else $error("clock not stretched after received byte");

    a_low_only: assert property (
        !serialDataOut && !serialClockOut)
        else $error("line driven high");
endmodule

`default_nettype wire

// file: tb/i2cs_master_model.sv
// Purpose: bus master model on the two-wire bus, both transmitting and receiving
// Assumes: lines are wired-and with pull-ups in the bench
// Notes: clock stands high outside frames
`timescale 1ns/1ps
`default_nettype none
module i2cs_master_model #(
    parameter int HALF = 250
) (
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sclLow,
    output logic sdaLow,
    output logic hung
);
    initial begin
        sclLow = 1'b0;
        sdaLow = 1'b0;
        hung = 1'b0;
    end
    // =========================================================
    // bus cycles
    task automatic waitHigh();
        int n;
        n = 0;
        while (sclIn !== 1'b1 && n < 4000) begin
            #5;
            n++;
        end
        if (n >= 4000) hung = 1'b1;
    endtask
    task automatic bitCycle(input logic b, output logic s);
        sdaLow = !b;
        #HALF;
        sclLow = 1'b0;
        waitHigh();
        #(HALF / 2);
        s = sdaIn;
        #(HALF / 2);
        sclLow = 1'b1;
    endtask
    task automatic startCond();
        sdaLow = 1'b1;
        #HALF;
        sclLow = 1'b1;
    endtask
    task automatic stopCond();
        sdaLow = 1'b1;
        #HALF;
        sclLow = 1'b0;
        waitHigh();
        #HALF;
        sdaLow = 1'b0;
        #HALF;
    endtask
    task automatic sendByte(input logic [7:0] b, output logic ackLow);
        logic s;
        for (int i = 7; i >= 0; i--) bitCycle(b[i], s);
        bitCycle(1'b1, s);
        ackLow = !s;
    endtask
    task automatic readByte(input logic ackIt, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitCycle(1'b1, s);
            b[i] = s;
        end
        bitCycle(!ackIt, s);
    endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Purpose: self-checking bench of the slave transmit path
// Assumes: software side is a process here, master is a model
// Notes: bus lines resolve wired-and with pull-ups
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic arst_n, stretch, txWrite, relClk, intClr, mScl, mSda, hung;
    logic sclOut, sclOe, sdaOut, sdaOe, rw, dataByte, nack, relBit, flag;
    logic [6:0] own;
    logic [7:0] txData, bufReg, wrByte, b;
    logic [7:0] txQ [8];
    logic [31:0] seed = 32'h56bd9d76;
    logic readMode, a;
    int fails = 0, tests_run = 0, nBytes, byteIdx, flagCount;
    wire logic scl;
    wire logic sda;
    assign scl = !(mScl || sclOe);
    assign sda = !(mSda || sdaOe);
    always #12.5 clk = ~clk;
    i2cs_slave_tx i_i2cs_slave_tx (.clk(clk), .arst_n(arst_n),
        .serialClockIn(scl), .serialClockOut(sclOut),
        .serialClockOe(sclOe), .serialDataIn(sda),
        .serialDataOut(sdaOut), .serialDataOe(sdaOe), .ownAddress(own),
        .clockStretchEnable(stretch), .txData(txData), .txWrite(txWrite),
        .releaseClock(relClk), .intClear(intClr), .serialBuffer(bufReg),
        .statusReadWrite(rw), .statusDataByte(dataByte),
        .statusNack(nack), .clockReleaseBit(relBit),
        .serialPortIntFlag(flag));
    i2cs_master_model i_i2cs_master_model (.sclIn(scl), .sdaIn(sda),
        .sclLow(mScl), .sdaLow(mSda), .hung(hung));
    // =========================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic rnd8(output logic [7:0] v);
        repeat (8) seed = lfsr(seed);
        v = seed[7:0];
    endtask
    task automatic checkBit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge hung) begin
        fails++;
        report_and_stop();
    end
    // =========================================================
    // software side: serve each interrupt
    always begin
        int n;
        logic holdExp;
        @(posedge clk);
        if (flag === 1'b1) begin
            holdExp = readMode ? (byteIdx < nBytes) : (byteIdx > 0);
            @(negedge clk);
            checkBit(sclOut | sdaOut, 1'b0);
            checkBit(scl, 1'b0);
            if (byteIdx == 0) checkBit(rw, readMode);
            if (byteIdx == 0 && readMode) checkByte(bufReg, {own, 1'b1});
            if (!readMode && byteIdx == 1) checkByte(bufReg, wrByte);
            checkBit(dataByte, byteIdx != 0);
            if (readMode && byteIdx > 0) checkBit(nack, !holdExp);
            repeat (3) @(negedge clk);
            if (holdExp) checkBit(sclOe, 1'b1);
            else if (readMode) checkBit(sclOe, 1'b0);
            @(posedge clk);
            if (readMode && holdExp) begin
                txData <= txQ[byteIdx];
                txWrite <= 1'b1;
                @(posedge clk);
                txWrite <= 1'b0;
                @(negedge clk);
                checkByte(bufReg, txQ[byteIdx]);
                checkBit(sclOe, 1'b1);
                @(posedge clk);
            end
            relClk <= 1'b1;
            intClr <= 1'b1;
            @(posedge clk);
            relClk <= 1'b0;
            intClr <= 1'b0;
            @(negedge clk);
            checkBit(relBit, 1'b1);
            checkBit(flag, 1'b0);
            flagCount++;
            byteIdx++;
            n = 0;
            while (flag !== 1'b0 && n < 20) begin
                @(posedge clk);
                n++;
            end
            if (n >= 20) fails++;
        end
    end
    // =========================================================
    // main sequence
    initial begin
        arst_n = 1'b0;
        rnd8(b);
        own = b[6:0];
        {stretch, txWrite, relClk, intClr, readMode} = 5'h0;
        txData = 8'h00;
        wrByte = 8'h00;
        nBytes = 0;
        byteIdx = 0;
        flagCount = 0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        for (int r = 1; r <= 3; r++) begin
            for (int i = 0; i < r; i++) rnd8(txQ[i]);
            if (r == 1) txQ[0] = 8'h80;
            readMode = 1'b1;
            nBytes = r;
            byteIdx = 0;
            flagCount = 0;
            i_i2cs_master_model.startCond();
            i_i2cs_master_model.sendByte({own, 1'b1}, a);
            checkBit(a, 1'b1);
            for (int i = 0; i < r; i++) begin
                i_i2cs_master_model.readByte(i < r - 1, b);
                checkByte(b, txQ[i]);
            end
            repeat (10) @(negedge clk);
            checkBit(nack, 1'b1);
            i_i2cs_master_model.readByte(1'b0, b);
            checkByte(b, 8'hff);
            i_i2cs_master_model.stopCond();
            checkByte(8'(flagCount), 8'(r + 1));
        end
        flagCount = 0;
        i_i2cs_master_model.startCond();
        i_i2cs_master_model.sendByte({own ^ 7'h40, 1'b1}, a);
        checkBit(a, 1'b0);
        i_i2cs_master_model.stopCond();
        checkByte(8'(flagCount), 8'h00);
        @(posedge clk);
        stretch <= 1'b1;
        readMode = 1'b0;
        byteIdx = 0;
        rnd8(wrByte);
        i_i2cs_master_model.startCond();
        i_i2cs_master_model.sendByte({own, 1'b0}, a);
        checkBit(a, 1'b1);
        i_i2cs_master_model.sendByte(wrByte, a);
        checkBit(a, 1'b1);
        i_i2cs_master_model.stopCond();
        checkByte(8'(flagCount), 8'h02);
        report_and_stop();
    end
endmodule
`default_nettype wire
